// [core/hsc_pkg.sv]
// package: constants and types of the eight-stage shift chain block
package hsc_pkg;

  // ==========================================================
  // geometry
  localparam int STAGES     = 8;
  localparam int WORD_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] CTRL_ADDR       = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR     = 8'h04;
  localparam logic [ADDR_W-1:0] STAGE_BASE_ADDR = 8'h40;
  localparam int                CTRL_FMT_BIT    = 0;
  localparam int                CTRL_HOLD_BIT   = 1;
  localparam logic [1:0]        CTRL_RESET      = 2'h0;
  localparam int                STAT_ACTIVE_BIT = 0;
  localparam int                STAT_FMT_BIT    = 1;
  localparam int                STAT_PEND_BIT   = 2;
  localparam int                STAT_FULL_BIT   = 3;

  // ==========================================================
  // types
  typedef enum logic {HSC_FWD, HSC_BWD} hsc_dir_t;

  typedef struct packed {
    hsc_dir_t          dir;
    logic [WORD_W-1:0] word;
  } hsc_req_t;

  localparam int REQ_W = $bits(hsc_req_t);

  // ==========================================================
  // address decode used by the register read path
  function automatic logic hsc_is_stage(input logic [ADDR_W-1:0] a);
    return (a >= STAGE_BASE_ADDR) && (a < STAGE_BASE_ADDR + 8'h20) &&
           (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] hsc_stage_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - STAGE_BASE_ADDR;
    return off[4:2];
  endfunction

endpackage

// [core/hsc_stream_if.sv]
// interface: valid/ready stream between the shift chain and its queue
`timescale 1ns/1ps
interface hsc_stream_if #(parameter int W = 33);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [core/hsc_fifo.sv]
// module: request queue with width and depth parameters
`timescale 1ns/1ps
module hsc_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  input  wire logic   flush_in,
  hsc_stream_if.snk   push,
  hsc_stream_if.src   pop
);
  // depth must be a power of two: pointers wrap on their own
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);

  assign push.ready = !full;
  assign pop.valid  = !empty;
  assign pop.data   = mem[rd_ptr[AW-1:0]];

  assign do_push = push.valid && !full && !flush_in;
  assign do_pop  = !empty && pop.ready && !flush_in;

  // ==========================================================
  // pointers
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush_in) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end else begin
      if (do_push) next_wr_ptr = wr_ptr + 1'b1;
      if (do_pop)  next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_push) mem[wr_ptr[AW-1:0]] <= push.data;
  end

  chk_no_overflow: assert property (@(posedge clk_in) disable iff (rst_in)
    full && !do_pop && !flush_in |=> full)
    else $error("queue lost its full state without a pop");

endmodule

// [core/hsc_edge_det.sv]
// module: rising edge detector for the shift pulse inputs
`timescale 1ns/1ps
module hsc_edge_det #(
  parameter int W = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out
);
  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  // a held pulse gives one rise only
  assign rise_out = level_in & ~prev;

  always_comb begin
    next_prev = level_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) prev <= '0;
    else        prev <= next_prev;
  end
endmodule

// [core/hsc_shift_chain_top.sv]
// module: eight-stage bidirectional shift chain with bit and word formats
`timescale 1ns/1ps
module hsc_shift_chain_top
  import hsc_pkg::*;
#(
  parameter int N_STAGES = STAGES,
  parameter int WW       = WORD_W,
  parameter int QDEPTH   = FIFO_DEPTH
) (
  input  wire logic                     CLK_IN,
  input  wire logic                     RESET_IN,
  input  wire logic                     ACTIVATION_COIL_IN,
  input  wire logic                     FORWARD_BIT_INPUT_IN,
  input  wire logic                     BACKWARD_BIT_INPUT_IN,
  input  wire logic signed [WW-1:0]     FORWARD_WORD_INPUT_IN,
  input  wire logic signed [WW-1:0]     BACKWARD_WORD_INPUT_IN,
  input  wire logic                     FORWARD_SHIFT_PULSE_IN,
  input  wire logic                     BACKWARD_SHIFT_PULSE_IN,
  input  wire logic                     CLEAR_COIL_IN,
  input  wire logic [ADDR_W-1:0]        REG_ADDR_IN,
  input  wire logic [31:0]              REG_WDATA_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic                     REG_RD_IN,
  output logic      [31:0]              REG_RDATA_OUT,
  output logic                          SHIFT_READY_OUT,
  output logic      [N_STAGES-1:0]      BIT_STAGE_CONTACTS_OUT,
  output logic      [N_STAGES*WW-1:0]   WORD_STAGE_OUTPUTS_OUT
);

  // ==========================================================
  // declarations
  logic                         active;
  logic                         clear;
  logic [1:0]                   rise;
  logic                         fwd_go;
  logic                         bwd_go;
  logic                         flush;
  logic signed [WW-1:0]         req_word;
  hsc_req_t                     ent;
  logic                         shift;
  logic                         shift_fwd;
  logic                         shift_bwd;
  logic [1:0]                   ctrl;
  logic [1:0]                   next_ctrl;
  logic                         fmt_dw;
  logic                         hold;
  logic [N_STAGES-1:0][WW-1:0]  store;
  logic [N_STAGES-1:0][WW-1:0]  next_store;
  logic [N_STAGES-1:0]          next_contacts;
  logic [N_STAGES*WW-1:0]       next_words;
  logic [31:0]                  next_rdata;

  hsc_stream_if #(.W(REQ_W)) req_s ();
  hsc_stream_if #(.W(REQ_W)) deq_s ();

  // ==========================================================
  // activation, clear and pulse edges
  assign active = ACTIVATION_COIL_IN;
  assign clear  = active && CLEAR_COIL_IN;
  assign fmt_dw = ctrl[CTRL_FMT_BIT];
  assign hold   = ctrl[CTRL_HOLD_BIT];

  hsc_edge_det #(.W(2)) u_edge (
    .clk_in   (CLK_IN),
    .rst_in   (RESET_IN),
    .level_in ({BACKWARD_SHIFT_PULSE_IN, FORWARD_SHIFT_PULSE_IN}),
    .rise_out (rise)
  );

  // a clear or a pair of coinciding pulses starts nothing
  assign fwd_go = active && rise[0] && !rise[1] && !clear;
  assign bwd_go = active && rise[1] && !rise[0] && !clear;

  // ==========================================================
  // request capture: data sampled at the pulse edge
  always_comb begin
    req_word = '0;
    if (fmt_dw) begin
      req_word = fwd_go ? FORWARD_WORD_INPUT_IN
                        : BACKWARD_WORD_INPUT_IN;
    end else begin
      // word inputs are ignored in bit format
      req_word[0] = fwd_go ? FORWARD_BIT_INPUT_IN
                           : BACKWARD_BIT_INPUT_IN;
    end
  end

  assign req_s.valid = fwd_go || bwd_go;
  assign req_s.data  = {(bwd_go ? HSC_BWD : HSC_FWD), req_word};
  assign SHIFT_READY_OUT = active && req_s.ready;

  // deactivation or clear throws away pending shifts
  assign flush = !active || clear;

  hsc_fifo #(.WIDTH(REQ_W), .DEPTH(QDEPTH)) u_fifo (
    .clk_in   (CLK_IN),
    .rst_in   (RESET_IN),
    .flush_in (flush),
    .push     (req_s),
    .pop      (deq_s)
  );

  // hold lets software freeze the chain while pulses queue up
  assign deq_s.ready = active && !hold && !clear;
  assign ent         = hsc_req_t'(deq_s.data);
  assign shift       = deq_s.valid && deq_s.ready;
  assign shift_fwd   = shift && (ent.dir == HSC_FWD);
  assign shift_bwd   = shift && (ent.dir == HSC_BWD);

  // ==========================================================
  // stage chain
  always_comb begin
    next_store = store;
    if (clear) begin
      next_store = '0;
    end else if (shift_fwd) begin
      next_store[0] = ent.word;
      for (int i = 1; i < N_STAGES; i++) begin
        next_store[i] = store[i-1];
      end
    end else if (shift_bwd) begin
      next_store[N_STAGES-1] = ent.word;
      for (int i = 0; i < N_STAGES-1; i++) begin
        next_store[i] = store[i+1];
      end
    end
  end

  // outputs track the next stage values so they settle with the shift
  always_comb begin
    next_contacts = '0;
    next_words    = '0;
    for (int i = 0; i < N_STAGES; i++) begin
      next_contacts[i] = fmt_dw ? 1'b0 : next_store[i][0];
    end
    if (fmt_dw) begin
      next_words = next_store;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      store                  <= '0;
      BIT_STAGE_CONTACTS_OUT <= '0;
      WORD_STAGE_OUTPUTS_OUT <= '0;
    end else begin
      store                  <= next_store;
      BIT_STAGE_CONTACTS_OUT <= next_contacts;
      WORD_STAGE_OUTPUTS_OUT <= next_words;
    end
  end

  // ==========================================================
  // register port
  always_comb begin
    next_ctrl = ctrl;
    if (REG_WR_IN && REG_ADDR_IN == CTRL_ADDR) begin
      next_ctrl = REG_WDATA_IN[1:0];
    end
  end

  always_comb begin
    next_rdata = '0;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == CTRL_ADDR) begin
        next_rdata[1:0] = ctrl;
      end else if (REG_ADDR_IN == STATUS_ADDR) begin
        next_rdata[STAT_ACTIVE_BIT] = active;
        next_rdata[STAT_FMT_BIT]    = fmt_dw;
        next_rdata[STAT_PEND_BIT]   = deq_s.valid;
        next_rdata[STAT_FULL_BIT]   = !req_s.ready;
      end else if (hsc_is_stage(REG_ADDR_IN)) begin
        next_rdata = store[hsc_stage_idx(REG_ADDR_IN)];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ctrl          <= CTRL_RESET;
      REG_RDATA_OUT <= '0;
    end else begin
      ctrl          <= next_ctrl;
      REG_RDATA_OUT <= next_rdata;
    end
  end

  // ==========================================================
  // checks
  sequence s_fwd_req;
    fwd_go && !deq_s.valid && req_s.ready;
  endsequence

  sequence s_bwd_req;
    bwd_go && !deq_s.valid && req_s.ready;
  endsequence

  sequence s_popped;
    deq_s.ready;
  endsequence

  chk_inactive_frozen: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !active |=> store == $past(store))
    else $error("stages changed while inactive");

  chk_inactive_ready: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !ACTIVATION_COIL_IN |-> !SHIFT_READY_OUT && !req_s.valid)
    else $error("request accepted while inactive");

  chk_fwd_load: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    s_fwd_req ##1 s_popped |=> store[0] == $past(req_word, 2))
    else $error("forward data not in stage one");

  chk_bwd_load: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    s_bwd_req ##1 s_popped |=>
      store[N_STAGES-1] == $past(req_word, 2))
    else $error("backward data not in last stage");

  chk_fwd_move: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    shift_fwd && !clear |=>
      store[N_STAGES-1:1] == $past(store[N_STAGES-2:0]))
    else $error("forward shift moved stages wrongly");

  chk_bwd_move: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    shift_bwd && !clear |=>
      store[N_STAGES-2:0] == $past(store[N_STAGES-1:1]))
    else $error("backward shift moved stages wrongly");

  chk_clear_wins: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    active && CLEAR_COIL_IN |=> store == '0 && !deq_s.valid)
    else $error("clear did not empty the chain");

  chk_pair_void: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    rise == 2'b11 |-> !req_s.valid)
    else $error("coinciding pulses produced a shift");

  chk_held_pulse: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    // a pulse already high at reset release counts as a fresh rise
    !$past(RESET_IN) && $past(FORWARD_SHIFT_PULSE_IN) &&
      FORWARD_SHIFT_PULSE_IN |-> !fwd_go)
    else $error("held pulse shifted again");

  chk_word_gate: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !fmt_dw |=> WORD_STAGE_OUTPUTS_OUT == '0)
    else $error("word outputs live in bit format");

  chk_bit_ignore: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    req_s.valid && !fmt_dw |-> req_word[WW-1:1] == '0)
    else $error("word input leaked in bit format");

  chk_fmt_default: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> ctrl == CTRL_RESET)
    else $error("format not bit after reset");

  chk_rdata_once: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == '0)
    else $error("read data outside its cycle");

endmodule

// [test/hsc_ctrl_model.sv]
// model of the surrounding control logic that drives the shift chain
`timescale 1ns/1ps
module hsc_ctrl_model (
  input  wire logic          clk_in,
  output logic               en_out,
  output logic               fp_out,
  output logic               bp_out,
  output logic               clr_out,
  output logic               fd_out,
  output logic               bd_out,
  output logic signed [31:0] fw_out,
  output logic signed [31:0] bw_out
);
  // ==========================================================
  // idle levels
  initial begin
    en_out  = 1'b0;
    fp_out  = 1'b0;
    bp_out  = 1'b0;
    clr_out = 1'b0;
    fd_out  = 1'b0;
    bd_out  = 1'b0;
    fw_out  = '0;
    bw_out  = '0;
  end

  // ==========================================================
  // activation level
  task automatic set_en(input logic v);
    @(posedge clk_in);
    en_out <= v;
  endtask

  // ==========================================================
  // one request: pulses, clear and data held for hold cycles
  task automatic shot(input logic f, input logic b, input logic c,
                      input logic [31:0] w, input int hold);
    @(posedge clk_in);
    fp_out  <= f;
    bp_out  <= b;
    clr_out <= c;
    fd_out  <= w[0];
    bd_out  <= w[0];
    fw_out  <= w;
    bw_out  <= w;
    repeat (hold) @(posedge clk_in);
    fp_out  <= 1'b0;
    bp_out  <= 1'b0;
    clr_out <= 1'b0;
    // data no longer valid: show the inverse so stale values never match
    fd_out  <= ~w[0];
    bd_out  <= ~w[0];
    fw_out  <= ~w;
    bw_out  <= ~w;
    // pulse stays low one cycle so the next rise is seen
    @(posedge clk_in);
  endtask
endmodule

// [test/hsc_shift_chain_top_tb.sv]
// self-checking bench of the shift chain block
`timescale 1ns/1ps
module hsc_shift_chain_top_tb;
  import hsc_pkg::*;
  logic               clk, rst, wr_s, rd_s, en, fp, bp, clr, fd, bd;
  logic signed [31:0] fw, bw;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata;
  logic               rdy;
  logic [7:0]         bits;
  logic [255:0]       words, expw;
  int                 n_errors, checks_done;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  hsc_ctrl_model ctl_u (.clk_in(clk), .en_out(en), .fp_out(fp), .bp_out(bp),
    .clr_out(clr), .fd_out(fd), .bd_out(bd), .fw_out(fw), .bw_out(bw));

  hsc_shift_chain_top dut_u (
    .CLK_IN                 (clk),
    .RESET_IN               (rst),
    .ACTIVATION_COIL_IN     (en),
    .FORWARD_BIT_INPUT_IN   (fd),
    .BACKWARD_BIT_INPUT_IN  (bd),
    .FORWARD_WORD_INPUT_IN  (fw),
    .BACKWARD_WORD_INPUT_IN (bw),
    .FORWARD_SHIFT_PULSE_IN (fp),
    .BACKWARD_SHIFT_PULSE_IN(bp),
    .CLEAR_COIL_IN          (clr),
    .REG_ADDR_IN            (addr),
    .REG_WDATA_IN           (wdata),
    .REG_WR_IN              (wr_s),
    .REG_RD_IN              (rd_s),
    .REG_RDATA_OUT          (rdata),
    .SHIFT_READY_OUT        (rdy),
    .BIT_STAGE_CONTACTS_OUT (bits),
    .WORD_STAGE_OUTPUTS_OUT (words)
  );

  // ==========================================================
  // comparison and verdict
  task automatic chk(input string n, input logic [255:0] s,
                     input logic [255:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // register bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // read data stand one cycle only, so the idle value is checked too
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(n, rdata, e);
    @(posedge clk);
    #1 chk("rdata_idle", rdata, 32'h0);
  endtask

  // shift takes two cycles, outputs update on the same edge as the stages
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // ==========================================================
  // scenarios
  initial begin
    n_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    chk("bits_reset", bits, 0);
    rd(CTRL_ADDR, 32'h0, "ctrl_reset");
    rd(8'h80, 32'h0, "unmapped");
    // bit format, forward
    ctl_u.set_en(1'b1);
    ctl_u.shot(1, 0, 0, 1, 1);
    ctl_u.shot(1, 0, 0, 0, 1);
    ctl_u.shot(1, 0, 0, 1, 1);
    settle(4);
    chk("bits_fwd", bits, 8'h05);
    chk("words_bitfmt", words, 0);
    // upper word bits set: bit format must keep only the data bit
    ctl_u.shot(1, 0, 0, 32'h7fff_fff1, 6);
    settle(4);
    chk("bits_held", bits, 8'h0b);
    rd(STAGE_BASE_ADDR, 32'h1, "stage1_bit");
    ctl_u.shot(1, 1, 0, 1, 1);
    settle(4);
    chk("bits_both", bits, 8'h0b);
    ctl_u.shot(1, 0, 1, 1, 1);
    settle(4);
    chk("bits_clr", bits, 8'h00);
    repeat (9) ctl_u.shot(1, 0, 0, 1, 1);
    settle(4);
    chk("bits_full", bits, 8'hff);
    ctl_u.shot(0, 1, 0, 0, 1);
    settle(4);
    chk("bits_bwd", bits, 8'h7f);
    // inactive block ignores shifts and clear
    ctl_u.set_en(1'b0);
    ctl_u.shot(1, 0, 0, 0, 1);
    ctl_u.shot(0, 0, 1, 0, 1);
    settle(4);
    chk("bits_inactive", bits, 8'h7f);
    chk("ready_inactive", rdy, 0);
    rd(STATUS_ADDR, 32'h0, "status_off");
    ctl_u.set_en(1'b1);
    // word format, most negative and most positive words; the most positive is shifted out before the check
    wr(CTRL_ADDR, 32'h1);
    ctl_u.shot(0, 0, 1, 0, 1);
    ctl_u.shot(1, 0, 0, 32'h8000_0000, 1);
    ctl_u.shot(1, 0, 0, 32'h7fff_ffff, 1);
    ctl_u.shot(0, 1, 0, 32'h0000_000a, 1);
    settle(4);
    chk("words_fwd_bwd", words,
        {32'h0000_000a, 192'h0, 32'h8000_0000});
    chk("bits_wordfmt", bits, 0);
    rd(STAGE_BASE_ADDR, 32'h8000_0000, "stage1");
    rd(8'h5c, 32'h0000_000a, "stage8");
    // queue held: fills, refuses the ninth, drains in order
    ctl_u.shot(0, 0, 1, 0, 1);
    wr(CTRL_ADDR, 32'h3);
    for (int i = 0; i < 9; i++) begin
      ctl_u.shot(1, 0, 0, i + 1, 1);
    end
    #1 chk("ready_full", rdy, 0);
    rd(STATUS_ADDR, 32'hf, "status_full");
    wr(CTRL_ADDR, 32'h1);
    settle(16);
    for (int i = 0; i < 8; i++) begin
      expw[32*i +: 32] = 32'(8 - i);
    end
    chk("words_drain", words, expw);
    chk("ready_drain", rdy, 1);
    complete_run();
  end
endmodule
